// ---- pkg/gpi_irq_consts.svh ----
// Summary of operation
// - Column mask bit n masks column n, default masked.
// - Row edge-select register at offset 0x5a.
// - Column edge-select register at offset 0x5b.
// - Clear: rising only; set: both edges.
// - Column mask register at offset 0x59.
`ifndef GPI_IRQ_CONSTS_SVH
`define GPI_IRQ_CONSTS_SVH
`define COL_MASK_OFFSET 8'h59
`define ROW_EDGE_OFFSET 8'h5a
`define COL_EDGE_OFFSET 8'h5b
`define STATUS_OFFSET 8'h60
`define CLEAR_OFFSET 8'h61
`define ENABLE_OFFSET 8'h62
`define COL_MASK_RESET 8'hff
`define EDGE_RESET 8'h00
`define STATUS_ROW_LSB 0
`define STATUS_COL_LSB 8
`endif

// ---- pkg/gpi_irq_pkg.sv ----
package gpi_irq_pkg;
   typedef enum logic [1:0] {
      bus_idle = 2'b00,
      bus_answer = 2'b01
   } bus_state_type;
endpackage

// ---- hdl/edge_qualifier.sv ----
`timescale 1ns/1ps
`include "gpi_irq_consts.svh"
module edge_qualifier #(
   parameter int WIDTH = 8
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic nrst,
   // Pin side
   input wire logic [WIDTH-1:0] pins,
   // Settings
   input wire logic [WIDTH-1:0] both_edges,
   input wire logic [WIDTH-1:0] mask,
   // Qualified events
   output logic [WIDTH-1:0] events
);
   logic [WIDTH-1:0] sync1;
   logic [WIDTH-1:0] sync2;
   logic [WIDTH-1:0] prev;

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         sync1 <= '0;
         sync2 <= '0;
         prev <= '0;
      end else begin
         sync1 <= pins;
         sync2 <= sync1;
         prev <= sync2;
      end
   end

   // Falls count only where both edges are selected.
   always_comb begin
      events = (sync2 & ~prev) | (both_edges & ~sync2 & prev);
      events = events & ~mask;
   end

   rise_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      (sync2[0] && !prev[0] && !mask[0]) |-> events[0])
      else $error("rising edge not reported");
   fall_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      (!sync2[0] && prev[0] && !both_edges[0]) |-> !events[0])
      else $error("fall reported in rising mode");
   fall_both_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      (!sync2[0] && prev[0] && both_edges[0] && !mask[0]) |-> events[0])
      else $error("fall not reported in both-edge mode");
   masked_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      |(events & mask) == 1'b0)
      else $error("masked input raised an event");
endmodule // edge_qualifier

// ---- hdl/gpi_irq_mask_edge_select.sv ----
`timescale 1ns/1ps
`include "gpi_irq_consts.svh"
module gpi_irq_mask_edge_select
   import gpi_irq_pkg::*;
#(
   parameter int LINES = 8
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic nrst,
   // Avalon-MM slave
   input wire logic [7:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   output logic [31:0] readdata,
   output logic waitrequest,
   // Matrix pins used as general purpose inputs
   input wire logic [LINES-1:0] matrix_line_inputs,
   input wire logic [LINES-1:0] matrix_column_inputs,
   // Interrupt
   output logic irq
);
   logic [LINES-1:0] column_interrupt_mask;
   logic [LINES-1:0] row_edge_select;
   logic [LINES-1:0] column_edge_select;
   logic [2*LINES-1:0] status;
   logic [2*LINES-1:0] enable;
   logic [LINES-1:0] row_events;
   logic [LINES-1:0] col_events;
   logic [LINES-1:0] row_mask_none;
   bus_state_type state;
   logic [31:0] next_readdata;
   logic wr_take;
   logic [2*LINES-1:0] clear_bits;
   logic [5:0] sel;

   // Bit positions of the one-hot register select.
   localparam int SEL_COL_MASK = 0;
   localparam int SEL_ROW_EDGE = 1;
   localparam int SEL_COL_EDGE = 2;
   localparam int SEL_STATUS = 3;
   localparam int SEL_CLEAR = 4;
   localparam int SEL_ENABLE = 5;

   // One decode feeds the read mux, the write path and the clear strobe,
   // so a register cannot read back at one offset and write at another.
   function automatic logic [5:0] reg_select(input logic [7:0] a);
      reg_select = 6'h00;
      if (a == `COL_MASK_OFFSET) begin
         reg_select[SEL_COL_MASK] = 1'b1;
      end else if (a == `ROW_EDGE_OFFSET) begin
         reg_select[SEL_ROW_EDGE] = 1'b1;
      end else if (a == `COL_EDGE_OFFSET) begin
         reg_select[SEL_COL_EDGE] = 1'b1;
      end else if (a == `STATUS_OFFSET) begin
         reg_select[SEL_STATUS] = 1'b1;
      end else if (a == `CLEAR_OFFSET) begin
         reg_select[SEL_CLEAR] = 1'b1;
      end else if (a == `ENABLE_OFFSET) begin
         reg_select[SEL_ENABLE] = 1'b1;
      end
   endfunction

   assign sel = reg_select(address);

   // Row masking lives elsewhere; rows here are always unmasked.
   assign row_mask_none = '0;

   edge_qualifier #(.WIDTH(LINES)) row_edges (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .pins(matrix_line_inputs),
      .both_edges(row_edge_select),
      .mask(row_mask_none),
      .events(row_events)
   );

   edge_qualifier #(.WIDTH(LINES)) col_edges (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .pins(matrix_column_inputs),
      .both_edges(column_edge_select),
      .mask(column_interrupt_mask),
      .events(col_events)
   );

   // Every access takes one wait cycle, so the answer is registered.
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         state <= bus_idle;
      end else begin
         case (state)
            bus_idle: begin
               if (read || write) begin
                  state <= bus_answer;
               end
            end
            default: begin
               state <= bus_idle;
            end
         endcase
      end
   end

   assign waitrequest = (read || write) && (state == bus_idle);
   assign wr_take = write && (state == bus_answer);

   always_comb begin
      next_readdata = 32'h00000000;
      if (sel[SEL_COL_MASK]) begin
         next_readdata[LINES-1:0] = column_interrupt_mask;
      end else if (sel[SEL_ROW_EDGE]) begin
         next_readdata[LINES-1:0] = row_edge_select;
      end else if (sel[SEL_COL_EDGE]) begin
         next_readdata[LINES-1:0] = column_edge_select;
      end else if (sel[SEL_STATUS]) begin
         next_readdata[2*LINES-1:0] = status;
      end else if (sel[SEL_ENABLE]) begin
         next_readdata[2*LINES-1:0] = enable;
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         readdata <= 32'h00000000;
      end else if (read && state == bus_idle) begin
         readdata <= next_readdata;
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         column_interrupt_mask <= `COL_MASK_RESET;
         row_edge_select <= `EDGE_RESET;
         column_edge_select <= `EDGE_RESET;
         enable <= '0;
      end else if (wr_take) begin
         if (sel[SEL_COL_MASK]) begin
            column_interrupt_mask <= writedata[LINES-1:0];
         end else if (sel[SEL_ROW_EDGE]) begin
            row_edge_select <= writedata[LINES-1:0];
         end else if (sel[SEL_COL_EDGE]) begin
            column_edge_select <= writedata[LINES-1:0];
         end else if (sel[SEL_ENABLE]) begin
            enable <= writedata[2*LINES-1:0];
         end
      end
   end

   always_comb begin
      clear_bits = '0;
      if (wr_take && sel[SEL_CLEAR]) begin
         clear_bits = writedata[2*LINES-1:0];
      end
   end

   // A new event in the clearing cycle survives the clear.
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         status <= '0;
      end else begin
         status <= (status & ~clear_bits) | {col_events, row_events};
      end
   end

   assign irq = |(status & enable);

   // A column status bit may only rise from an event of an unmasked column.
   col_mask_a: assert property (@(posedge ref_clk)
      disable iff (!nrst)
      ((status[2*LINES-1:LINES] & ~$past(status[2*LINES-1:LINES]))
      & $past(column_interrupt_mask)) == '0)
      else $error("masked column set its status bit");
   wr_mask_a: assert property (@(posedge ref_clk)
      disable iff (!nrst)
      (wr_take && address == `COL_MASK_OFFSET)
      |=> column_interrupt_mask == $past(writedata[LINES-1:0]))
      else $error("column mask write lost");
   wr_row_edge_a: assert property (@(posedge ref_clk)
      disable iff (!nrst)
      (wr_take && address == `ROW_EDGE_OFFSET)
      |=> row_edge_select == $past(writedata[LINES-1:0]))
      else $error("row edge-select write lost");
   wr_col_edge_a: assert property (@(posedge ref_clk)
      disable iff (!nrst)
      (wr_take && address == `COL_EDGE_OFFSET)
      |=> column_edge_select == $past(writedata[LINES-1:0]))
      else $error("column edge-select write lost");
   wr_enable_a: assert property (@(posedge ref_clk)
      disable iff (!nrst)
      (wr_take && address == `ENABLE_OFFSET)
      |=> enable == $past(writedata[2*LINES-1:0]))
      else $error("enable write lost");

   sticky_event_a: assert property (@(posedge ref_clk)
      disable iff (!nrst)
      (row_events[0]) |=> status[0])
      else $error("event did not set status");
   status_hold_a: assert property (@(posedge ref_clk)
      disable iff (!nrst)
      ($past(status) & ~$past(clear_bits) & ~status) == '0)
      else $error("status bit dropped without a clear");
   status_cause_a: assert property (@(posedge ref_clk)
      disable iff (!nrst)
      (status & ~$past(status) & ~$past({col_events, row_events})) == '0)
      else $error("status bit set without an event");
   clear_a: assert property (@(posedge ref_clk)
      disable iff (!nrst)
      (wr_take && address == `CLEAR_OFFSET)
      |=> (status & $past(writedata[2*LINES-1:0])
      & ~$past({col_events, row_events})) == '0)
      else $error("cleared status bit stayed set");
   irq_level_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      irq == |(status & enable))
      else $error("interrupt output disagrees with status");
   bus_answer_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      (read && waitrequest) |=> !waitrequest)
      else $error("read not answered in one cycle");
   write_answer_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      (write && waitrequest) |=> !waitrequest)
      else $error("write not answered in one cycle");
   read_upper_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      (read && !waitrequest) |-> readdata[31:2*LINES] == '0)
      else $error("unused read data bits not zero");
endmodule // gpi_irq_mask_edge_select

// ---- verification/host_model.sv ----
`timescale 1ns/1ps
module host_model (
   // Clock
   input wire logic ref_clk,
   // Avalon-MM master
   output logic [7:0] address,
   output logic read,
   output logic write,
   output logic [31:0] writedata,
   input wire logic [31:0] readdata,
   input wire logic waitrequest
);
   initial begin
      address = 8'h00;
      read = 1'b0;
      write = 1'b0;
      writedata = 32'h0;
   end
   // Released address and data are inverted so a stale value never looks valid.
   task automatic access(input logic we, input logic [7:0] a,
                         input logic [31:0] d, output logic [31:0] q);
      @(posedge ref_clk);
      address <= a;
      read <= !we;
      write <= we;
      writedata <= d;
      // Waitrequest and read data are taken at the rising edge only.
      do @(posedge ref_clk); while (waitrequest !== 1'b0);
      q = readdata;
      read <= 1'b0;
      write <= 1'b0;
      address <= ~a;
      writedata <= ~d;
   endtask
endmodule // host_model

// ---- verification/tb_top.sv ----
`timescale 1ns/1ps
`include "gpi_irq_consts.svh"
module tb_top;
   logic ref_clk, nrst, read, write, waitrequest, irq;
   logic [7:0] address, rows, cols;
   logic [31:0] writedata, readdata;
   int err_count, check_count;
   gpi_irq_mask_edge_select #(.LINES(8)) u_dut (.ref_clk(ref_clk),
      .nrst(nrst), .address(address), .read(read), .write(write),
      .writedata(writedata), .readdata(readdata),
      .waitrequest(waitrequest), .matrix_line_inputs(rows),
      .matrix_column_inputs(cols), .irq(irq));
   host_model u_host (.ref_clk(ref_clk), .address(address), .read(read),
      .write(write), .writedata(writedata), .readdata(readdata),
      .waitrequest(waitrequest));
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] q;
      u_host.access(1'b0, a, 32'h0, q);
      check(q, exp);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      u_host.access(1'b1, a, d, q);
   endtask
   // Rows have no mask in this block, so only columns are gated.
   function automatic logic [15:0] expect_ev(logic [7:0] ro, rn, rs,
         co, cn, cs, cm);
      expect_ev[7:0] = (rn & ~ro) | (ro & ~rn & rs);
      expect_ev[15:8] = ((cn & ~co) | (co & ~cn & cs)) & ~cm;
   endfunction
   task automatic give_verdict;
      $display("checks=%0d errors=%0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   initial begin
      #100000;
      err_count++;
      give_verdict();
   end
   initial begin
      logic [7:0] ro, rn, co, cn, rs, cs, cm;
      logic [15:0] en, ev;
      nrst = 1'b0;
      rows = 8'h00;
      cols = 8'h00;
      void'($urandom(18950));
      repeat (5) @(posedge ref_clk);
      nrst <= 1'b1;
      rd_chk(`COL_MASK_OFFSET, 32'hff);
      rd_chk(`ROW_EDGE_OFFSET, 32'h0);
      rd_chk(`COL_EDGE_OFFSET, 32'h0);
      rd_chk(`STATUS_OFFSET, 32'h0);
      rd_chk(`ENABLE_OFFSET, 32'h0);
      wr(8'h10, 32'($urandom));
      rd_chk(8'h10, 32'h0);
      ro = 8'h00;
      co = 8'h00;
      // Pass 0: all columns masked, all rising; pass 1: all falling, rising only.
      for (int i = 0; i < 24; i++) begin
         rs = (i < 2) ? {8{i == 0}} : 8'($urandom);
         cs = (i < 2) ? {8{i == 0}} : 8'($urandom);
         cm = (i < 2) ? {8{i == 0}} : 8'($urandom);
         rn = (i < 2) ? {8{i == 0}} : 8'($urandom);
         cn = (i < 2) ? {8{i == 0}} : 8'($urandom);
         en = 16'($urandom);
         wr(`ROW_EDGE_OFFSET, {24'h0, rs});
         wr(`COL_EDGE_OFFSET, {24'h0, cs});
         wr(`COL_MASK_OFFSET, {24'h0, cm});
         wr(`ENABLE_OFFSET, {16'h0, en});
         rd_chk(`ROW_EDGE_OFFSET, {24'h0, rs});
         rd_chk(`COL_EDGE_OFFSET, {24'h0, cs});
         rd_chk(`COL_MASK_OFFSET, {24'h0, cm});
         rd_chk(`ENABLE_OFFSET, {16'h0, en});
         wr(`CLEAR_OFFSET, 32'hffff);
         rd_chk(`STATUS_OFFSET, 32'h0);
         @(posedge ref_clk);
         rows <= rn;
         cols <= cn;
         repeat (8) @(posedge ref_clk);
         ev = expect_ev(ro, rn, rs, co, cn, cs, cm);
         rd_chk(`STATUS_OFFSET, {16'h0, ev});
         check({31'h0, irq}, {31'h0, |(ev & en)});
         ro = rn;
         co = cn;
      end
      give_verdict();
   end
endmodule // tb_top
